/* hdl/hppm_consts.vh */
// Purpose: constants for the host parallel port pin mapping block
// Assumes: one 40 MHz clock, host pins synchronous to it
// Notes: address is a word index, byte bits 1:0 never carried
// Overview of operation
// RULE_01: mode strap 0 makes each shared low pin a plain data bit.
// RULE_02: mode strap 1 makes shared low pins carry address then data.
// RULE_03: multiplexed address starts at bit 2; bits 1 and 0 never sent.
// RULE_04: data pins driven only while host holds output enable low.
// RULE_05: write strobe low means write, high means read.
// RULE_06: data bus is 32 bits wide, bits 0 to 31, both directions.
// RULE_07: in multiplexed mode the address bit 2 pin is the latch strobe.
// RULE_08: nonmultiplexed address lines sampled on chip select falling edge.
// RULE_09: every address selects one whole 32-bit word.
// RULE_10: data pins released while chip select inactive or during write.
`ifndef HPPM_CONSTS_VH
`define HPPM_CONSTS_VH
`define HPPM_DATA_W 32
`define HPPM_WADDR_LSB 2
`define HPPM_WADDR_MSB 5
`define HPPM_MODE_NONMUX 1'h0
`define HPPM_MODE_MUX 1'h1
`define HPPM_DATA_RST 32'h00000000
`define HPPM_ADDR_RST 4'h0
`endif

/* hdl/hppm_edge.v */
// Purpose: falling- and rising-edge detector for an active-low host strobe
// Assumes: input synchronous to clk
// Notes: idle level is high after reset
`timescale 1ns/1ps
module hppm_edge (
  clk,
  rst_b,
  sig,
  fall,
  rise
);
  input wire clk;
  input wire rst_b;
  input wire sig;
  output wire fall;
  output wire rise;
  reg last_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= 1'h1;
    end else begin
      last_q <= sig;
    end
  end
  assign fall = last_q & ~sig;
  assign rise = ~last_q & sig;
endmodule // hppm_edge

/* hdl/hppm_port.v */
// Purpose: host parallel bus port, muxed or nonmuxed, 32-bit words
// Assumes: host pins synchronous to clk; strap stable while chip select low
// Notes: user side offers one word address and a read/write strobe pair
`timescale 1ns/1ps
`include "hppm_consts.vh"
module hppm_port #(
  parameter DATA_W = `HPPM_DATA_W
) (
  clk,
  rst_b,
  bus_mode_select,
  cs_b,
  oe_b,
  we_b,
  addr_line_bit2_ale,
  addr_line_bit3,
  addr_line_bit4,
  addr_line_bit5,
  data_in,
  data_out,
  data_oe,
  word_addr,
  wr_strobe,
  wr_data,
  rd_strobe,
  rd_data
);
  input wire clk;
  input wire rst_b;
  input wire bus_mode_select;
  input wire cs_b;
  input wire oe_b;
  input wire we_b;
  input wire addr_line_bit2_ale;
  input wire addr_line_bit3;
  input wire addr_line_bit4;
  input wire addr_line_bit5;
  input wire [DATA_W-1:0] data_in;
  output wire [DATA_W-1:0] data_out;
  output wire [DATA_W-1:0] data_oe;
  output wire [`HPPM_WADDR_MSB-`HPPM_WADDR_LSB:0] word_addr;
  output wire wr_strobe;
  output wire [DATA_W-1:0] wr_data;
  output wire rd_strobe;
  input wire [DATA_W-1:0] rd_data;

  localparam AW = `HPPM_WADDR_MSB - `HPPM_WADDR_LSB + 1;
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [AW-1:0] addr_q;
  reg [AW-1:0] addr_d;
  reg [DATA_W-1:0] rdat_q;
  reg [DATA_W-1:0] wdat_q;
  reg wr_q;
  reg rd_q;
  reg wr_pend_q;
  reg rd_seen_q;

  wire cs_fall;
  wire cs_rise;
  wire ale_fall;
  wire we_rise;
  wire mux_mode;
  wire [AW-1:0] pin_addr;
  wire [AW-1:0] shared_addr;
  wire in_data;
  wire stay_data;
  wire xfer_open;
  wire rd_take;
  wire drive;

  // phase decode shared by strobe and drive logic
  function is_data;
    input [1:0] st;
    begin
      is_data = (st == ST_DATA);
    end
  endfunction

  // detectors idle high: no false edge out of reset
  hppm_edge u_cs_edge (
    .clk(clk),
    .rst_b(rst_b),
    .sig(cs_b),
    .fall(cs_fall),
    .rise(cs_rise)
  );
  // latch strobe active high; address captured as it falls
  hppm_edge u_ale_edge (
    .clk(clk),
    .rst_b(rst_b),
    .sig(~addr_line_bit2_ale),
    .fall(),
    .rise(ale_fall)
  );
  hppm_edge u_we_edge (
    .clk(clk),
    .rst_b(rst_b),
    .sig(we_b),
    .fall(),
    .rise(we_rise)
  );

  assign mux_mode = (bus_mode_select == `HPPM_MODE_MUX); // RULE_02
  // separate lines, bit 2 upward
  assign pin_addr = {addr_line_bit5, addr_line_bit4, addr_line_bit3, addr_line_bit2_ale}; // RULE_09
  // shared pins carry word address, lsb on data bit 2
  assign shared_addr = data_in[`HPPM_WADDR_MSB:`HPPM_WADDR_LSB]; // RULE_03
  assign in_data = is_data(state_q);
  assign stay_data = is_data(state_d);
  // chip select low inside a transfer phase
  assign xfer_open = in_data & ~cs_b;

  always @* begin
    state_d = state_q;
    addr_d = addr_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          if (mux_mode) begin
            state_d = ST_ADDR; // RULE_07
          end else begin
            addr_d = pin_addr; // RULE_08
            state_d = ST_DATA; // RULE_01
          end
        end
      end
      ST_ADDR: begin
        if (cs_b) begin
          state_d = ST_IDLE;
        end else if (ale_fall) begin
          addr_d = shared_addr; // RULE_02
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
        end else if (mux_mode && ale_fall) begin
          addr_d = shared_addr; // RULE_07
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // phase and word address
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      addr_q <= `HPPM_ADDR_RST;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // write taken at strobe release, data whole 32-bit word
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdat_q <= `HPPM_DATA_RST;
      wr_q <= 1'h0;
      wr_pend_q <= 1'h0;
    end else begin
      wr_q <= 1'h0;
      if (xfer_open) begin
        if (!we_b) begin
          wr_pend_q <= 1'h1; // RULE_05
          wdat_q <= data_in; // RULE_06
        end
        if (we_rise && wr_pend_q) begin
          wr_q <= 1'h1; // RULE_05
          wr_pend_q <= 1'h0;
        end
      end else begin
        // cycle cut before strobe release: word dropped
        wr_pend_q <= 1'h0;
      end
    end
  end

  // one fetch per chip select cycle, never a repeat
  assign rd_take = xfer_open & stay_data & we_b & ~oe_b &
    ~wr_pend_q & ~rd_q & ~rd_seen_q; // RULE_05

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'h0;
      rd_seen_q <= 1'h0;
      rdat_q <= `HPPM_DATA_RST;
    end else begin
      rd_q <= rd_take;
      if (!in_data) begin
        rd_seen_q <= 1'h0;
      end else if (rd_q) begin
        rd_seen_q <= 1'h1;
      end
      // word lands one cycle after the fetch strobe
      if (rd_q) begin
        rdat_q <= rd_data; // RULE_09
      end
    end
  end

  // old word shows until the fetch lands
  assign drive = xfer_open & ~oe_b & we_b; // RULE_04 RULE_10
  assign data_out = rdat_q; // RULE_06

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_oe
      assign data_oe[gi] = drive; // RULE_04
    end
  endgenerate

  assign word_addr = addr_q; // RULE_09
  assign wr_strobe = wr_q;
  assign wr_data = wdat_q;
  assign rd_strobe = rd_q;
endmodule // hppm_port

/* verification/hppm_port_sva.sv */
// Purpose: port checks for hppm_port
// Assumes: one clk domain
// Notes: bound to every hppm_port
`timescale 1ns/1ps
module hppm_port_sva (
  input logic clk,
  input logic rst_b,
  input logic bus_mode_select,
  input logic cs_b,
  input logic oe_b,
  input logic we_b,
  input logic addr_line_bit2_ale,
  input logic addr_line_bit3,
  input logic addr_line_bit4,
  input logic addr_line_bit5,
  input logic [31:0] data_in,
  input logic [31:0] data_out,
  input logic [31:0] data_oe,
  input logic [3:0] word_addr,
  input logic wr_strobe,
  input logic [31:0] wr_data,
  input logic rd_strobe,
  input logic [31:0] rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_CS_IDLE: assert property (cs_b |-> data_oe == 0) else $error("cs idle drive");
  AST_WE_LOW: assert property (!we_b |-> data_oe == 0) else $error("write drive");
  AST_OE_HIGH: assert property (oe_b |-> data_oe == 0) else $error("oe high drive");
  AST_OE_WORD: assert property (data_oe == 0 || &data_oe) else $error("part word");
  AST_WR_DONE: assert property ($rose(we_b) && !cs_b |-> ##[0:2] wr_strobe) else $error("no wr");
  AST_RD_WORD: assert property (rd_strobe |-> ##1 data_out == $past(rd_data)) else $error("rd word");
  AST_RD_PULSE: assert property (rd_strobe |=> !rd_strobe) else $error("rd pulse long");
  AST_WR_PULSE: assert property (wr_strobe |=> !wr_strobe) else $error("wr pulse long");
  AST_RD_DIR: assert property (rd_strobe |-> $past(we_b) && !$past(oe_b)) else $error("rd not read");
  AST_ADR_NMUX: assert property (!bus_mode_select && $fell(cs_b) |-> ##2 word_addr ==
    $past({addr_line_bit5, addr_line_bit4, addr_line_bit3, addr_line_bit2_ale}, 2)) else $error("addr0");
  AST_ADR_MUX: assert property (bus_mode_select && $fell(addr_line_bit2_ale) |-> ##2
    word_addr == $past(data_in[5:2], 2)) else $error("addr1");
endmodule // hppm_port_sva
bind hppm_port hppm_port_sva hppm_port_sva_i (
  .clk(clk),
  .rst_b(rst_b),
  .bus_mode_select(bus_mode_select),
  .cs_b(cs_b),
  .oe_b(oe_b),
  .we_b(we_b),
  .addr_line_bit2_ale(addr_line_bit2_ale),
  .addr_line_bit3(addr_line_bit3),
  .addr_line_bit4(addr_line_bit4),
  .addr_line_bit5(addr_line_bit5),
  .data_in(data_in),
  .data_out(data_out),
  .data_oe(data_oe),
  .word_addr(word_addr),
  .wr_strobe(wr_strobe),
  .wr_data(wr_data),
  .rd_strobe(rd_strobe),
  .rd_data(rd_data)
);

/* verification/hppm_user_mem.sv */
// Purpose: user word store facing hppm_port
// Assumes: write on wr_strobe
// Notes: read word shown at once
`timescale 1ns/1ps
module hppm_user_mem (
  input logic clk,
  input logic [3:0] word_addr,
  input logic wr_strobe,
  input logic [31:0] wr_data,
  output logic [31:0] rd_data
);
  logic [31:0] mem [16];
  always @(posedge clk) begin
    if (wr_strobe) mem[word_addr] <= wr_data;
  end
  assign rd_data = mem[word_addr];
endmodule // hppm_user_mem

/* verification/hppm_port_tb.sv */
// Purpose: bench for hppm_port
// Assumes: host pins move at falling edge
// Notes: word store is the partner
`timescale 1ns/1ps
module hppm_port_tb;
  logic clk, rst_b, bus_mode_select, cs_b, oe_b, we_b, wr_strobe, rd_strobe;
  logic addr_line_bit2_ale, addr_line_bit3, addr_line_bit4, addr_line_bit5;
  logic [31:0] data_in, data_out, data_oe, wr_data, rd_data;
  logic [3:0] word_addr;
  int miscompares = 0;
  int n_tests = 0;
  int rd_cnt = 0;
  hppm_port hppm_port_i (
    .clk(clk),
    .rst_b(rst_b),
    .bus_mode_select(bus_mode_select),
    .cs_b(cs_b),
    .oe_b(oe_b),
    .we_b(we_b),
    .addr_line_bit2_ale(addr_line_bit2_ale),
    .addr_line_bit3(addr_line_bit3),
    .addr_line_bit4(addr_line_bit4),
    .addr_line_bit5(addr_line_bit5),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .word_addr(word_addr),
    .wr_strobe(wr_strobe),
    .wr_data(wr_data),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data)
  );
  hppm_user_mem hppm_user_mem_i (
    .clk(clk),
    .word_addr(word_addr),
    .wr_strobe(wr_strobe),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );
  // fetch strobes seen, one per read access expected
  always @(negedge clk) begin
    if (rd_strobe === 1'b1) rd_cnt++;
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string s);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one access; wrong address source carries ~a
  task automatic acc(input logic m, w, input logic [3:0] a, input logic [31:0] d);
    int n;
    int c0;
    c0 = rd_cnt;
    @(negedge clk) bus_mode_select = m;
    @(negedge clk) cs_b = 0;
    {addr_line_bit5, addr_line_bit4, addr_line_bit3} = m ? ~a[3:1] : a[3:1];
    addr_line_bit2_ale = m | a[0];
    data_in = m ? {26'h2aaaaaa, a, 2'h3} : {26'h0, ~a, 2'h0};
    @(negedge clk) addr_line_bit2_ale = !m & a[0];
    repeat (2) @(negedge clk);
    data_in = d;
    oe_b = 0;
    we_b = !w;
    repeat (3) @(negedge clk);
    if (w) begin
      chk(data_oe === 0, "write drive");
      we_b = 1;
      oe_b = 1;
      for (n = 0; n < 4 && wr_strobe !== 1; n++) @(negedge clk);
      chk(wr_strobe === 1 && wr_data === d && word_addr === a, "wr word");
    end else chk(data_oe === '1 && data_out === d && word_addr === a, "rd word");
    @(negedge clk) cs_b = 1;
    oe_b = 1;
    @(negedge clk) chk(data_oe === 0, "release");
    chk(rd_cnt == c0 + (w ? 0 : 1), "fetch count");
  endtask
  task automatic t_nmux;
    acc(0, 1, 4'h9, 32'hdeadbeef);
    acc(0, 0, 4'h9, 32'hdeadbeef);
  endtask
  task automatic t_mux;
    acc(1, 1, 4'h6, 32'h80000001);
    acc(1, 0, 4'h6, 32'h80000001);
    acc(1, 0, 4'h9, 32'hdeadbeef);
  endtask
  task automatic t_idle;
    @(negedge clk) oe_b = 0;
    repeat (2) @(negedge clk);
    chk(data_oe === 0, "no cs drive");
    oe_b = 1;
  endtask
  initial begin
    {rst_b, cs_b, oe_b, we_b, bus_mode_select} = 5'h0e;
    {addr_line_bit5, addr_line_bit4, addr_line_bit3, addr_line_bit2_ale} = 4'h0;
    data_in = 32'h0;
    repeat (4) @(negedge clk);
    rst_b = 1;
    t_nmux();
    t_mux();
    t_idle();
    end_of_test();
  end
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule // hppm_port_tb
